// ### fdc_regs_pkg.sv
/*
 drive control register bank constants: offsets, field positions, reset values, timing.
 assumes an 8-bit host data bus with a 10-bit i/o address.
*/
package fdc_regs_pkg;
   localparam logic [9:0] ADDR_STATUS_B   = 10'h3f1;
   localparam logic [9:0] ADDR_DRIVE_CTRL = 10'h3f2;
   localparam logic [9:0] ADDR_TAPE_SEL   = 10'h3f3;
   localparam logic [9:0] ADDR_DIG_IN     = 10'h3f7;
   localparam int DOR_SEL_LSB   = 0;
   localparam int DOR_RESET_BIT = 2;
   localparam int DOR_DMA_BIT   = 3;
   localparam int DOR_MOT_LSB   = 4;
   localparam logic [7:0] DOR_RESET_VAL  = 8'h00;
   localparam logic [1:0] TAPE_RESET_VAL = 2'h0;
   localparam int CLK_PERIOD_NS   = 10;
   localparam int SOFT_RESET_MIN_NS = 100;
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      MODE_BASIC     = 2'b00,
      MODE_ENHANCED  = 2'b01,
      MODE_ALTERNATE = 2'b11
   } status_mode_t;
endpackage

// ### fdc_sync_edge.sv
/*
 two-flop synchroniser with rise and fall pulses on the controller clock.
 assumes the input is asynchronous; reset is the synchronised copy.
*/
`timescale 1ns/100ps
module fdc_sync_edge (
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   input  wire logic i_async,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic meta;
   logic stage;
   logic last;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta  <= 1'b0;
         stage <= 1'b0;
         last  <= 1'b0;
      end else begin
         meta  <= i_async;
         stage <= meta;
         last  <= stage;
      end
   end
   assign o_level = stage;
   assign o_rise  = stage & ~last;
   assign o_fall  = ~stage & last;
endmodule // fdc_sync_edge

// ### fdc_drive_regs.sv
/*
 drive control registers: status b, drive output control, tape select, four-drive decode.
 assumes a synchronous host strobe interface on i_mclk; drive pins are asynchronous.
*/
// Summary of operation
// - enhanced status b bits 1:0 show motor outputs 1 and 0, hardware reset clears.
// - enhanced status b bit 2 shows the live write gate level.
// - enhanced status b bit 3 toggles on each inactive read data edge.
// - enhanced status b bit 4 toggles on each inactive write data edge.
// - enhanced status b bit 5 mirrors drive select bit 0.
// - enhanced status b bits 7:6 always read one.
// - alternate status b shows select outputs 2,3,0,1 and second drive present.
// - alternate bit 2 latches on write gate rising, cleared by input register read.
// - alternate bit 3 latches on read data inactive edge, cleared by input read.
// - alternate bit 4 latches on write data inactive edge, not gated by write gate.
// - drive control register always writable, kept through software reset.
// - bits 1:0 pick one of four drive selects.
// - bit 2 at zero holds software reset until one is written.
// - software reset lasts at least 100 ns; back-to-back writes suffice.
// - basic and alternate modes: dma bit gates request, ack, count and interrupt.
// - enhanced mode keeps dma pins enabled always; the bit still resets to zero.
// - bits 7:4 drive motor outputs 0 to 3.
// - tape select bits have no internal effect, kept through software reset.
// - tape register read drives only bits 1:0; bits 7:2 undriven.
// - tape select code zero means none, one to three select drives.
// - select goes low only with matching motor bit; motor pins are inverted bits.
// - basic mode status b read leaves the data bus undriven.
`timescale 1ns/100ps
module fdc_drive_regs
   import fdc_regs_pkg::*;
(
   input  wire logic                       i_mclk,
   input  wire logic                       i_rst_n,
   input  wire logic [9:0]                 i_addr,
   input  wire logic                       i_rd,
   input  wire logic                       i_wr,
   input  wire logic [7:0]                 i_wdata,
   input  wire fdc_regs_pkg::status_mode_t i_mode,
   input  wire logic                       i_drive_swap,
   input  wire logic                       i_write_gate,
   input  wire logic                       i_write_data,
   input  wire logic                       i_read_data_n,
   input  wire logic                       i_second_drive_present_n,
   output logic [7:0]                      o_rdata,
   output logic [7:0]                      o_rdata_oe_n,
   output logic [3:0]                      o_drive_select_n,
   output logic [3:0]                      o_motor_n,
   output logic                            o_soft_reset,
   output logic                            o_dma_pins_enable,
   output logic [1:0]                      o_tape_select
);
   import fdc_regs_pkg::*;

   logic rst_meta;
   logic rst_sync_n;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // drive pins are off-clock; every one goes through a synchroniser
   logic wg_lvl, wg_rise, rd_lvl, rd_fall, wd_fall, drv2_lvl;
   logic wg_f_unused, rd_r_unused, wd_lvl_unused, wd_r_unused, d2_r_unused, d2_f_unused;
   fdc_sync_edge u_write_gate_out (
      .i_mclk  (i_mclk),
      .i_rst_n (rst_sync_n),
      .i_async (i_write_gate),
      .o_level (wg_lvl),
      .o_rise  (wg_rise),
      .o_fall  (wg_f_unused)
   );
   // read data pin is active low; its inactive edge is the rising edge of the pin
   fdc_sync_edge u_rdata (
      .i_mclk  (i_mclk),
      .i_rst_n (rst_sync_n),
      .i_async (~i_read_data_n),
      .o_level (rd_lvl),
      .o_rise  (rd_r_unused),
      .o_fall  (rd_fall)
   );
   fdc_sync_edge u_wdata (
      .i_mclk  (i_mclk),
      .i_rst_n (rst_sync_n),
      .i_async (i_write_data),
      .o_level (wd_lvl_unused),
      .o_rise  (wd_r_unused),
      .o_fall  (wd_fall)
   );
   // second drive level is only shown, never edge-detected
   fdc_sync_edge u_drv2 (
      .i_mclk  (i_mclk),
      .i_rst_n (rst_sync_n),
      .i_async (i_second_drive_present_n),
      .o_level (drv2_lvl),
      .o_rise  (d2_r_unused),
      .o_fall  (d2_f_unused)
   );

   wire sel_srb  = (i_addr == ADDR_STATUS_B);
   wire sel_dor  = (i_addr == ADDR_DRIVE_CTRL);
   wire sel_tape = (i_addr == ADDR_TAPE_SEL);
   wire dir_read = i_rd & (i_addr == ADDR_DIG_IN);
   wire wr_dor   = i_wr & sel_dor;
   wire wr_tape  = i_wr & sel_tape;

   logic [7:0] drive_output_control;
   logic [1:0] tape_select_holding;
   always_ff @(posedge i_mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         drive_output_control <= DOR_RESET_VAL;
         tape_select_holding  <= TAPE_RESET_VAL;
      end else begin
         if (wr_dor) drive_output_control <= i_wdata;
         if (wr_tape) tape_select_holding <= i_wdata[1:0];
      end
   end

   wire [1:0] drive_num = drive_output_control[DOR_SEL_LSB +: 2];
   wire [3:0] motor_bits = drive_output_control[DOR_MOT_LSB +: 4];
   // swap exchanges drive 0 and 1 on both the select and motor mapping
   wire [1:0] phys_num = (i_drive_swap && !drive_num[1]) ? {1'b0, ~drive_num[0]} : drive_num;
   wire [3:0] phys_mot = i_drive_swap ? {motor_bits[3:2], motor_bits[0], motor_bits[1]} : motor_bits;
   wire [3:0] one_hot = 4'h1 << phys_num;
   wire [3:0] next_sel_n = ~(one_hot & phys_mot);
   wire [3:0] next_mot_n = ~phys_mot;

   // software reset stretched to the minimum width even for back-to-back writes
   logic [3:0] srst_cnt;
   wire srst_req = ~drive_output_control[DOR_RESET_BIT];
   always_ff @(posedge i_mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) srst_cnt <= 4'h0;
      else if (srst_req) srst_cnt <= 4'(SOFT_RESET_CYCLES);
      else if (srst_cnt != 4'h0) srst_cnt <= srst_cnt - 4'h1;
   end

   // toggle and latch bits; set wins over a same-cycle read clear
   logic rd_tog, wd_tog, wg_ff, rd_ff, wd_ff;
   always_ff @(posedge i_mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_tog <= 1'b0;
         wd_tog <= 1'b0;
         wg_ff  <= 1'b0;
         rd_ff  <= 1'b0;
         wd_ff  <= 1'b0;
      end else begin
         if (rd_fall) rd_tog <= ~rd_tog;
         if (wd_fall) wd_tog <= ~wd_tog;
         wg_ff <= wg_rise | (wg_ff & ~dir_read);
         rd_ff <= rd_fall | (rd_ff & ~dir_read);
         wd_ff <= wd_fall | (wd_ff & ~dir_read);
      end
   end

   // motor bits follow the live pins, so a swap is reflected too
   wire [7:0] srb_enh = {2'b11, drive_num[0], wd_tog, rd_tog, wg_lvl, ~o_motor_n[1:0]};
   wire [7:0] srb_alt = {drv2_lvl, o_drive_select_n[1], o_drive_select_n[0], wd_ff, rd_ff, wg_ff,
                         o_drive_select_n[3], o_drive_select_n[2]};
   wire        srb_drive = i_rd & sel_srb & (i_mode != MODE_BASIC);
   wire        tape_drive = i_rd & sel_tape;
   wire        dor_drive = i_rd & sel_dor;
   wire [7:0] next_rdata = srb_drive ? ((i_mode == MODE_ENHANCED) ? srb_enh : srb_alt)
                         : dor_drive ? drive_output_control
                         : tape_drive ? {6'h00, tape_select_holding} : 8'h00;
   wire [7:0] next_oe_n = (srb_drive | dor_drive) ? 8'h00
                        : tape_drive ? 8'hfc : 8'hff;
   wire next_dma_en = (i_mode == MODE_ENHANCED) | drive_output_control[DOR_DMA_BIT];

   always_ff @(posedge i_mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         o_rdata           <= 8'h00;
         o_rdata_oe_n      <= 8'hff;
         o_drive_select_n  <= 4'hf;
         o_motor_n         <= 4'hf;
         o_soft_reset      <= 1'b0;
         o_tape_select     <= 2'h0;
      end else begin
         o_rdata           <= next_rdata;
         o_rdata_oe_n      <= next_oe_n;
         o_drive_select_n  <= next_sel_n;
         o_motor_n         <= next_mot_n;
         o_soft_reset      <= srst_req | (srst_cnt != 4'h0);
         o_tape_select     <= tape_select_holding;
      end
   end

   // no reset here: enhanced mode keeps the dma pins enabled even while reset holds
   // the register at zero, which makes next_dma_en follow the mode alone
   always_ff @(posedge i_mclk) begin
      o_dma_pins_enable <= next_dma_en;
   end

   chk_soft_reset_width: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      $rose(o_soft_reset) |-> o_soft_reset [*8]) else $error("soft reset too short");
   chk_reset_hold: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      srst_req |=> o_soft_reset) else $error("soft reset not asserted");
   chk_one_select: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      $onehot0(~o_drive_select_n)) else $error("more than one drive selected");
   chk_select_needs_motor: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      (o_motor_n == 4'hf) |-> (o_drive_select_n == 4'hf)) else $error("select without motor");
   chk_motor_follow: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      wr_dor && !i_drive_swap ##1 !i_drive_swap |=> o_motor_n == ~$past(i_wdata[7:4], 2))
      else $error("motor outputs wrong");
   chk_rd_toggle: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      rd_fall |=> rd_tog != $past(rd_tog)) else $error("read toggle missed");
   chk_wd_toggle: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      wd_fall |=> wd_tog != $past(wd_tog)) else $error("write toggle missed");
   chk_wg_latch: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      wg_rise |=> wg_ff) else $error("write gate latch missed");
   chk_rd_latch: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      rd_fall |=> rd_ff) else $error("read data latch missed");
   chk_wd_clear: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      dir_read && !wd_fall |=> !wd_ff) else $error("write data latch not cleared");
   chk_basic_float: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      i_rd && sel_srb && i_mode == MODE_BASIC |=> o_rdata_oe_n == 8'hff)
      else $error("status b driven in basic mode");
   chk_tape_float: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      i_rd && sel_tape |=> o_rdata_oe_n == 8'hfc) else $error("tape read lanes wrong");
   chk_dma_enh: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      i_mode == MODE_ENHANCED |=> o_dma_pins_enable) else $error("dma pins gated in enhanced");
   chk_enh_reserved: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      srb_drive && i_mode == MODE_ENHANCED |=> o_rdata[7:6] == 2'b11) else $error("reserved bits");

   // status b read-back, checked against the sources one cycle earlier
   chk_enh_motor_bits: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      srb_drive && i_mode == MODE_ENHANCED |=> o_rdata[1:0] == ~$past(o_motor_n[1:0]))
      else $error("status b motor bits wrong");
   chk_enh_write_gate_out: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      srb_drive && i_mode == MODE_ENHANCED |=> o_rdata[2] == $past(wg_lvl))
      else $error("status b write gate wrong");
   chk_enh_dsel0: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      srb_drive && i_mode == MODE_ENHANCED |=> o_rdata[5] == $past(drive_output_control[0]))
      else $error("status b drive select wrong");
   chk_alt_selects: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      srb_drive && i_mode == MODE_ALTERNATE |=>
         {o_rdata[6:5], o_rdata[1:0]} == $past({o_drive_select_n[1:0], o_drive_select_n[3:2]}))
      else $error("alternate select bits wrong");
   chk_alt_drv2: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      srb_drive && i_mode == MODE_ALTERNATE |=> o_rdata[7] == $past(drv2_lvl))
      else $error("alternate drive present wrong");

   // latch clears and the write data latch set; a same-cycle set is excluded from the clears because set wins
   chk_wg_clear: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      dir_read && !wg_rise |=> !wg_ff)
      else $error("write gate latch not cleared");
   chk_rd_clear: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      dir_read && !rd_fall |=> !rd_ff)
      else $error("read data latch not cleared");
   chk_wd_latch: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      wd_fall |=> wd_ff)
      else $error("write data latch missed");

   // register storage and output mapping
   chk_dor_write: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      wr_dor |=> drive_output_control == $past(i_wdata))
      else $error("drive control write lost");
   chk_tape_store: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      wr_tape |=> tape_select_holding == $past(i_wdata[1:0]))
      else $error("tape select write lost");
   chk_tape_read: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      i_rd && sel_tape |=> o_rdata[1:0] == $past(tape_select_holding))
      else $error("tape select read wrong");
   chk_srst_release: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      !srst_req && srst_cnt == 4'h0 |=> !o_soft_reset)
      else $error("soft reset stuck");
   chk_dma_gated: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      i_mode != MODE_ENHANCED |=> o_dma_pins_enable == $past(drive_output_control[DOR_DMA_BIT]))
      else $error("dma gate does not follow bit");
   chk_motor_map: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      !i_drive_swap |=> o_motor_n == ~$past(drive_output_control[7:4]))
      else $error("motor mapping wrong");
   chk_swap_map: assert property (@(posedge i_mclk) disable iff (!rst_sync_n)
      i_drive_swap && drive_output_control[1:0] == 2'h0 && drive_output_control[4] |=>
         o_drive_select_n == 4'hd)
      else $error("swapped drive 0 not on select 1");

   cov_soft_reset: cover property (@(posedge i_mclk) disable iff (!rst_sync_n) $fell(o_soft_reset));
   cov_swap_select: cover property (@(posedge i_mclk) disable iff (!rst_sync_n)
      i_drive_swap && o_drive_select_n == 4'hd);
   cov_alt_latches: cover property (@(posedge i_mclk) disable iff (!rst_sync_n)
      wg_ff && rd_ff && wd_ff);
   cov_drive3: cover property (@(posedge i_mclk) disable iff (!rst_sync_n) o_drive_select_n == 4'h7);
   cov_dir_clear: cover property (@(posedge i_mclk) disable iff (!rst_sync_n) dir_read && wg_ff);
endmodule // fdc_drive_regs

// ### fdc_drive_model.sv
/*
 drive side model: read and write data pulses, write gate level, second drive present.
 assumes bench commands are sampled on the controller clock.
*/
`timescale 1ns/100ps
module fdc_drive_model #(
   parameter logic P_DRV2_N = 1'b0
) (
   input  wire logic i_mclk,
   input  wire logic i_rd_kick,
   input  wire logic i_wd_kick,
   input  wire logic i_wg_on,
   output logic      o_read_data_n,
   output logic      o_write_data,
   output logic      o_write_gate,
   output logic      o_second_drive_present_n
);
   logic [1:0] rd_cnt = 2'h0;
   logic [1:0] wd_cnt = 2'h0;
   logic       wg_q   = 1'b0;
   // three-cycle pulses so the synchronisers never miss one
   always_ff @(posedge i_mclk) begin
      rd_cnt <= i_rd_kick ? 2'h3 : rd_cnt - {1'b0, rd_cnt != 2'h0};
      wd_cnt <= i_wd_kick ? 2'h3 : wd_cnt - {1'b0, wd_cnt != 2'h0};
      wg_q   <= i_wg_on;
   end
   assign o_read_data_n            = (rd_cnt == 2'h0);
   assign o_write_data             = (wd_cnt != 2'h0);
   assign o_write_gate             = wg_q;
   assign o_second_drive_present_n = P_DRV2_N;
endmodule // fdc_drive_model

// ### fdc_drive_regs_tb_top.sv
/*
 self-checking bench for the drive control registers.
 assumes the drive model on the pin side and a 100 MHz clock.
*/
`timescale 1ns/100ps
module fdc_drive_regs_tb_top;
   import fdc_regs_pkg::*;
   logic         i_mclk = 1'b0, i_rst_n = 1'b0, i_rd = 1'b0, i_wr = 1'b0, i_drive_swap = 1'b0;
   logic [9:0]   i_addr = 10'h0;
   logic [7:0]   i_wdata = 8'h0, o_rdata, o_rdata_oe_n, d;
   status_mode_t i_mode = MODE_BASIC;
   logic         i_write_gate, i_write_data, i_read_data_n, i_second_drive_present_n;
   logic [3:0]   o_drive_select_n, o_motor_n;
   logic         o_soft_reset, o_dma_pins_enable;
   logic [1:0]   o_tape_select;
   logic         rd_kick = 1'b0, wd_kick = 1'b0, wg_on = 1'b0, rtog = 1'b0, wtog = 1'b0;
   int           fails = 0, compares = 0;
   logic [7:0]   tbl [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
   fdc_drive_regs fdc_drive_regs_inst (.i_mclk, .i_rst_n, .i_addr, .i_rd, .i_wr, .i_wdata, .i_mode, .i_drive_swap,
      .i_write_gate, .i_write_data, .i_read_data_n, .i_second_drive_present_n, .o_rdata, .o_rdata_oe_n,
      .o_drive_select_n, .o_motor_n, .o_soft_reset, .o_dma_pins_enable, .o_tape_select);
   fdc_drive_model fdc_drive_model_inst (.i_mclk, .i_rd_kick(rd_kick), .i_wd_kick(wd_kick), .i_wg_on(wg_on),
      .o_read_data_n(i_read_data_n), .o_write_data(i_write_data), .o_write_gate(i_write_gate),
      .o_second_drive_present_n(i_second_drive_present_n));
   initial forever #5 i_mclk = ~i_mclk;
   // expected {selects_n, motors_n}; swap moves drive and motor bit 0 and 1
   function automatic logic [7:0] dec(input logic [7:0] v, input logic s);
      logic [3:0] m;
      logic [1:0] p;
      m = v[7:4];
      p = v[1:0];
      if (s) begin
         m = {m[3:2], m[0], m[1]};
         p = (p < 2'h2) ? p ^ 2'h1 : p;
      end
      return {~(m[p] ? 4'h1 << p : 4'h0), ~m};
   endfunction
   function automatic logic [7:0] aexp(input logic [2:0] f);
      logic [7:0] e;
      e = dec(8'h25, 1'b0);
      return {1'b0, e[5], e[4], f, e[7], e[6]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      repeat (3) @(posedge i_mclk);
      #1;
   endtask
   task automatic rd(input logic [9:0] a);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
   endtask
   task automatic kick(input logic w);
      @(posedge i_mclk);
      rd_kick <= !w;
      wd_kick <= w;
      @(posedge i_mclk);
      rd_kick <= 1'b0;
      wd_kick <= 1'b0;
      repeat (8) @(posedge i_mclk);
      if (w) wtog = !wtog;
      else rtog = !rtog;
   endtask
   task automatic results;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      results;
   end
   initial begin
      void'($urandom(32'ha3d4));
      repeat (10) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_mclk);
      #1;
      chk({o_drive_select_n, o_motor_n}, 8'hff);
      chk({6'h0, o_soft_reset, o_dma_pins_enable}, 8'h02);
      for (int s = 0; s < 2; s++)
         for (int n = 0; n < 4; n++) begin
            @(posedge i_mclk) i_drive_swap <= s[0];
            wr(ADDR_DRIVE_CTRL, tbl[n]);
            chk({o_drive_select_n, o_motor_n}, dec(tbl[n], s[0]));
         end
      repeat (24) begin
         d = 8'($urandom) | 8'h04;
         @(posedge i_mclk) i_drive_swap <= 1'($urandom_range(1));
         wr(ADDR_DRIVE_CTRL, d);
         chk({o_drive_select_n, o_motor_n}, dec(d, i_drive_swap));
         chk({7'h0, o_dma_pins_enable}, {7'h0, d[3]});
      end
      chk({7'h0, o_soft_reset}, 8'h00);
      for (int t = 0; t < 4; t++) begin
         wr(ADDR_TAPE_SEL, {6'h3f, t[1:0]});
         rd(ADDR_TAPE_SEL);
         chk(o_rdata_oe_n, 8'hfc);
         chk({4'h0, o_rdata[1:0], o_tape_select}, {4'h0, t[1:0], t[1:0]});
      end
      // clear then set the reset bit on consecutive edges
      @(posedge i_mclk);
      i_addr <= ADDR_DRIVE_CTRL;
      i_wdata <= 8'h18;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wdata <= 8'h1c;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
      chk({7'h0, o_soft_reset}, 8'h01);
      rd(ADDR_DRIVE_CTRL);
      chk(o_rdata, 8'h1c);
      chk({6'h0, o_tape_select}, 8'h03);
      repeat (15) @(posedge i_mclk);
      #1;
      chk({7'h0, o_soft_reset}, 8'h00);
      @(posedge i_mclk);
      i_mode <= MODE_ENHANCED;
      i_drive_swap <= 1'b0;
      wg_on <= 1'b1;
      wr(ADDR_DRIVE_CTRL, 8'h25);
      chk({7'h0, o_dma_pins_enable}, 8'h01);
      repeat (3) kick(1'($urandom_range(1)));
      rd(ADDR_STATUS_B);
      chk(o_rdata, {3'b111, wtog, rtog, 3'b110});
      @(posedge i_mclk);
      i_mode <= MODE_ALTERNATE;
      wg_on <= 1'b0;
      wr(ADDR_DRIVE_CTRL, 8'h25);
      chk({7'h0, o_dma_pins_enable}, 8'h00);
      rd(ADDR_DIG_IN);
      rd(ADDR_STATUS_B);
      chk(o_rdata, aexp(3'b000));
      @(posedge i_mclk) wg_on <= 1'b1;
      kick(1'b0);
      kick(1'b1);
      rd(ADDR_STATUS_B);
      chk(o_rdata, aexp(3'b111));
      rd(ADDR_DIG_IN);
      rd(ADDR_STATUS_B);
      chk(o_rdata, aexp(3'b000));
      @(posedge i_mclk) wg_on <= 1'b0;
      kick(1'b1);
      rd(ADDR_STATUS_B);
      chk(o_rdata, aexp(3'b100));
      @(posedge i_mclk) i_mode <= MODE_BASIC;
      rd(ADDR_STATUS_B);
      chk(o_rdata_oe_n, 8'hff);
      rd(10'h3f0);
      chk(o_rdata_oe_n, 8'hff);
      results;
   end
endmodule // fdc_drive_regs_tb_top
